// [rtl/fcs_host.v]
// Host controller that drives flash command sequences over the parallel pins
`timescale 1ns/1ps
`include "fcs_defs.vh"
module fcs_host (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        ce,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_ff,
  output wire [19:0] flash_addr,
  output wire [15:0] flash_dq_out,
  output wire        flash_dq_oe,
  input  wire [15:0] flash_dq_in,
  output wire        flash_ce_n,
  output wire        flash_we_n,
  output wire        flash_oe_n,
  output reg         flash_byte_n_ff,
  output reg         flash_reset_n_ff,
  input  wire        ready_busy_out_n
);
  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  localparam [5:0] S_IDLE  = 6'b000001;
  localparam [5:0] S_ISSUE = 6'b000010;
  localparam [5:0] S_WAIT  = 6'b000100;
  localparam [5:0] S_POLL  = 6'b001000;
  localparam [5:0] S_HWRST = 6'b010000;
  localparam [5:0] S_READ  = 6'b100000;

  reg [5:0]  st_ff;
  reg [3:0]  op_ff;
  reg [2:0]  step_ff;
  reg [19:0] addr_ff;
  reg [15:0] wdata_ff;
  reg [15:0] rdata_ff;
  reg        busy_ff;
  reg        done_flag_ff;
  reg        tmo_ff;
  reg        bypass_ff;
  reg        ident_ff;
  reg        reject_ff;
  reg [16:0] wait_ff;
  reg        go_wr_ff;
  reg        go_rd_ff;
  reg [19:0] cyc_addr_ff;
  reg [15:0] cyc_data_ff;
  reg        rdy_q_ff;
  wire        cyc_done;
  wire [15:0] cyc_rdata;

  fcs_bus_cycle u_cyc (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .go_wr     (go_wr_ff),
    .go_rd     (go_rd_ff),
    .addr      (cyc_addr_ff),
    .wdata     (cyc_data_ff),
    .dq_in     (flash_dq_in),
    .done_ff   (cyc_done),
    .rdata_ff  (cyc_rdata),
    .fa_ff     (flash_addr),
    .dq_out_ff (flash_dq_out),
    .dq_oe_ff  (flash_dq_oe),
    .ce_n_ff   (flash_ce_n),
    .we_n_ff   (flash_we_n),
    .oe_n_ff   (flash_oe_n)
  );

  // Sequence length for each order
  function [2:0] seq_len;
    input [3:0] op;
    begin
      case (op)
        `FCS_OP_IDENT:      seq_len = 3'd3;
        `FCS_OP_RESET:      seq_len = 3'd1;
        `FCS_OP_PROG:       seq_len = 3'd4;
        `FCS_OP_BYP_ENTER:  seq_len = 3'd3;
        `FCS_OP_BYP_PROG:   seq_len = 3'd2;
        `FCS_OP_BYP_EXIT:   seq_len = 3'd2;
        `FCS_OP_CHIP_ERASE: seq_len = 3'd6;
        default:            seq_len = 3'd0;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // Address and data of each sequence step
  // ---------------------------------------------------------------
  reg [19:0] s_addr;
  reg [15:0] s_data;
  reg        unl;
  always @* begin
    s_addr = 20'h0_0000;
    s_data = 16'h0000;
    unl    = 1'b0;
    case (op_ff)
      `FCS_OP_IDENT: begin
        unl    = (step_ff < 3'd2);
        s_data = `FCS_CMD_IDENT;
      end
      `FCS_OP_RESET: s_data = `FCS_CMD_RESET;
      `FCS_OP_PROG: begin
        unl    = (step_ff < 3'd2);
        s_data = (step_ff == 3'd2) ? `FCS_CMD_PROG : wdata_ff;
        if (step_ff == 3'd3)
          s_addr = addr_ff;
      end
      `FCS_OP_BYP_ENTER: begin
        unl    = (step_ff < 3'd2);
        s_data = `FCS_CMD_BYP_ENTER;
      end
      `FCS_OP_BYP_PROG: begin
        s_data = (step_ff == 3'd0) ? `FCS_CMD_PROG : wdata_ff;
        if (step_ff == 3'd1)
          s_addr = addr_ff;
      end
      `FCS_OP_BYP_EXIT:
        s_data = (step_ff == 3'd0) ? `FCS_CMD_BYP_EXIT1 : `FCS_CMD_BYP_EXIT2;
      // six cycles ending in chip erase
      `FCS_OP_CHIP_ERASE: begin
        unl    = (step_ff != 3'd2) && (step_ff != 3'd5);
        s_data = (step_ff == 3'd2) ? `FCS_CMD_ERASE_SET : `FCS_CMD_CHIP_ERS;
      end
      default: s_data = 16'h0000;
    endcase
    // exact unlock pairs, alternating first and second
    if (unl) begin
      if (step_ff[0] == 1'b0 && step_ff != 3'd4) begin
        s_addr = flash_byte_n_ff ? `FCS_UNLOCK1_ADDR : `FCS_UNLOCK1_ADDRB;
        s_data = `FCS_UNLOCK1_DATA;
      end else begin
        s_addr = flash_byte_n_ff ? `FCS_UNLOCK2_ADDR : `FCS_UNLOCK2_ADDRB;
        s_data = `FCS_UNLOCK2_DATA;
      end
      if (step_ff == 3'd3 || step_ff == 3'd4) begin
        s_addr = (step_ff == 3'd3)
               ? (flash_byte_n_ff ? `FCS_UNLOCK1_ADDR : `FCS_UNLOCK1_ADDRB)
               : (flash_byte_n_ff ? `FCS_UNLOCK2_ADDR : `FCS_UNLOCK2_ADDRB);
        s_data = (step_ff == 3'd3) ? `FCS_UNLOCK1_DATA : `FCS_UNLOCK2_DATA;
      end
    end
  end

  // Order legality in the current mode
  reg [3:0] req_op;
  reg       legal;
  always @* begin
    req_op = reg_wdata[3:0];
    legal  = 1'b1;
    // bypass mode admits only bypass program, exit, read and hardware reset
    if (bypass_ff)
      legal = (req_op == `FCS_OP_BYP_PROG) || (req_op == `FCS_OP_BYP_EXIT) ||
              (req_op == `FCS_OP_READ) || (req_op == `FCS_OP_HW_RESET);
    else if (req_op == `FCS_OP_BYP_PROG || req_op == `FCS_OP_BYP_EXIT)
      legal = 1'b0;
    if (req_op == 4'h0 || req_op > `FCS_OP_HW_RESET)
      legal = 1'b0;
  end

  wire start = reg_wr && (reg_addr == `FCS_REG_CTRL);

  // ---------------------------------------------------------------
  // Sequencer and registers
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff            <= S_IDLE;
      op_ff            <= 4'h0;
      step_ff          <= 3'd0;
      addr_ff          <= 20'h0_0000;
      wdata_ff         <= 16'h0000;
      rdata_ff         <= 16'h0000;
      busy_ff          <= 1'b0;
      done_flag_ff     <= 1'b0;
      tmo_ff           <= 1'b0;
      bypass_ff        <= 1'b0;
      ident_ff         <= 1'b0;
      reject_ff        <= 1'b0;
      wait_ff          <= 17'h0_0000;
      go_wr_ff         <= 1'b0;
      go_rd_ff         <= 1'b0;
      cyc_addr_ff      <= 20'h0_0000;
      cyc_data_ff      <= 16'h0000;
      rdy_q_ff         <= 1'b1;
      reg_rdata_ff     <= 32'h0000_0000;
      flash_byte_n_ff  <= 1'b1;
      flash_reset_n_ff <= 1'b1;
    end else if (ce) begin
      go_wr_ff <= 1'b0;
      go_rd_ff <= 1'b0;
      rdy_q_ff <= ready_busy_out_n;
      if (reg_wr && reg_addr == `FCS_REG_ADDR)
        addr_ff <= reg_wdata[19:0];
      if (reg_wr && reg_addr == `FCS_REG_WDATA)
        wdata_ff <= reg_wdata[15:0];
      reg_rdata_ff <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `FCS_REG_CTRL:   reg_rdata_ff <= {27'h000_0000, ~flash_byte_n_ff, op_ff};
          `FCS_REG_ADDR:   reg_rdata_ff <= {12'h000, addr_ff};
          `FCS_REG_WDATA:  reg_rdata_ff <= {16'h0000, wdata_ff};
          `FCS_REG_STATUS: reg_rdata_ff <= {26'h000_0000, reject_ff, ident_ff, bypass_ff,
                                            tmo_ff, done_flag_ff, busy_ff};
          `FCS_REG_RDATA:  reg_rdata_ff <= {16'h0000, rdata_ff};
          default:         reg_rdata_ff <= 32'h0000_0000;
        endcase
      end
      case (st_ff)
        S_IDLE: begin
          if (start) begin
            // orders are ignored while busy, without setting reject, so only taken in idle
            if (legal) begin
              op_ff        <= req_op;
              step_ff      <= 3'd0;
              busy_ff      <= 1'b1;
              done_flag_ff <= 1'b0;
              tmo_ff       <= 1'b0;
              reject_ff    <= 1'b0;
              // byte or word width from the control bit, held unchanged while in bypass mode
              if (!bypass_ff)
                flash_byte_n_ff <= ~reg_wdata[`FCS_CTRL_BYTE_BIT];
              if (req_op == `FCS_OP_HW_RESET) begin
                flash_reset_n_ff <= 1'b0;
                wait_ff          <= 17'h0_0000;
                st_ff            <= S_HWRST;
              end else if (req_op == `FCS_OP_READ) begin
                cyc_addr_ff <= addr_ff;
                go_rd_ff    <= 1'b1;
                st_ff       <= S_READ;
              end else
                st_ff <= S_ISSUE;
            end else
              reject_ff <= 1'b1;
          end
        end
        S_ISSUE: begin
          cyc_addr_ff <= s_addr;
          cyc_data_ff <= s_data;
          go_wr_ff    <= 1'b1;
          st_ff       <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (step_ff + 3'd1 < seq_len(op_ff)) begin
              step_ff <= step_ff + 3'd1;
              st_ff   <= S_ISSUE;
            end else if (op_ff == `FCS_OP_PROG || op_ff == `FCS_OP_BYP_PROG ||
                         op_ff == `FCS_OP_CHIP_ERASE) begin
              wait_ff <= 17'h0_0000;
              st_ff   <= S_POLL;
            end else begin
              // reset returns to array reads, clearing identify
              if (op_ff == `FCS_OP_IDENT)
                ident_ff <= 1'b1;
              if (op_ff == `FCS_OP_RESET)
                ident_ff <= 1'b0;
              if (op_ff == `FCS_OP_BYP_ENTER)
                bypass_ff <= 1'b1;
              if (op_ff == `FCS_OP_BYP_EXIT)
                bypass_ff <= 1'b0;
              busy_ff      <= 1'b0;
              done_flag_ff <= 1'b1;
              st_ff        <= S_IDLE;
            end
          end
        end
        S_POLL: begin
          // device runs its own algorithm, host only waits
          // no command issued while the device is busy
          wait_ff <= wait_ff + 17'h0_0001;
          if (wait_ff > 17'h0_0002 && rdy_q_ff) begin
            busy_ff      <= 1'b0;
            done_flag_ff <= 1'b1;
            st_ff        <= S_IDLE;
          end else if (wait_ff == `FCS_POLL_LIMIT) begin
            // a stuck program shows as timeout; reset needed after
            tmo_ff  <= 1'b1;
            busy_ff <= 1'b0;
            st_ff   <= S_IDLE;
          end
        end
        S_HWRST: begin
          // hardware reset aborts; host returns to idle without resending the sequence
          wait_ff <= wait_ff + 17'h0_0001;
          if (wait_ff + 17'h0_0001 >= `FCS_RST_CYC) begin
            flash_reset_n_ff <= 1'b1;
            bypass_ff        <= 1'b0;
            ident_ff         <= 1'b0;
            busy_ff          <= 1'b0;
            done_flag_ff     <= 1'b1;
            st_ff            <= S_IDLE;
          end
        end
        S_READ: begin
          if (cyc_done) begin
            // identify reads return codes from the device
            rdata_ff     <= cyc_rdata;
            busy_ff      <= 1'b0;
            done_flag_ff <= 1'b1;
            st_ff        <= S_IDLE;
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end
endmodule

// [include/fcs_defs.vh]
// Constants for the flash command-sequence host controller
// What this block does
// - Identify entry is two unlock writes then the identify command; reads give codes.
// - Host writes the reset command to leave identify mode.
// - Standard program is two unlocks, setup command, then address and data.
// - Hardware reset aborts programming; the host does not repeat the sequence afterwards.
// - Bypass entry is two unlocks then command data 20h.
// - Bypass program is A0h then address and data, repeatable.
// - Bypass exit writes 90h then 00h at any address.
// - Chip erase is two unlocks, setup, two unlocks, chip erase command.
`ifndef FCS_DEFS_VH
`define FCS_DEFS_VH
// Software register offsets
`define FCS_REG_CTRL      4'h0
`define FCS_REG_ADDR      4'h1
`define FCS_REG_WDATA     4'h2
`define FCS_REG_STATUS    4'h3
`define FCS_REG_RDATA     4'h4
// Control register command codes (low bits of CTRL write)
`define FCS_OP_READ       4'h1
`define FCS_OP_IDENT      4'h2
`define FCS_OP_RESET      4'h3
`define FCS_OP_PROG       4'h4
`define FCS_OP_BYP_ENTER  4'h5
`define FCS_OP_BYP_PROG   4'h6
`define FCS_OP_BYP_EXIT   4'h7
`define FCS_OP_CHIP_ERASE 4'h8
`define FCS_OP_HW_RESET   4'h9
`define FCS_CTRL_BYTE_BIT 4
// Status register bits
`define FCS_ST_BUSY       0
`define FCS_ST_DONE       1
`define FCS_ST_TIMEOUT    2
`define FCS_ST_BYPASS     3
`define FCS_ST_IDENT      4
`define FCS_ST_REJECT     5
// Flash command addresses and data (word mode; byte mode uses the alternate)
`define FCS_UNLOCK1_ADDR  20'h0_0555
`define FCS_UNLOCK1_ADDRB 20'h0_0AAA
`define FCS_UNLOCK2_ADDR  20'h0_02AA
`define FCS_UNLOCK2_ADDRB 20'h0_0555
`define FCS_UNLOCK1_DATA  16'h00AA
`define FCS_UNLOCK2_DATA  16'h0055
`define FCS_CMD_IDENT     16'h0090
`define FCS_CMD_RESET     16'h00F0
`define FCS_CMD_PROG      16'h00A0
`define FCS_CMD_BYP_ENTER 16'h0020
`define FCS_CMD_BYP_EXIT1 16'h0090
`define FCS_CMD_BYP_EXIT2 16'h0000
`define FCS_CMD_ERASE_SET 16'h0080
`define FCS_CMD_CHIP_ERS  16'h0010
// Bus timing in cycles of the 100 ns clock
`define FCS_CLK_NS        100
`define FCS_WE_LOW_NS     100
`define FCS_WE_CYC        ((`FCS_WE_LOW_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_ACC_NS        200
`define FCS_ACC_CYC       ((`FCS_ACC_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_RST_NS        500
`define FCS_RST_CYC       ((`FCS_RST_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_POLL_LIMIT    100000
`endif

// [rtl/fcs_bus_cycle.v]
// One flash bus cycle: a write pulse or a timed read
`timescale 1ns/1ps
`include "fcs_defs.vh"
module fcs_bus_cycle (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        ce,
  input  wire        go_wr,
  input  wire        go_rd,
  input  wire [19:0] addr,
  input  wire [15:0] wdata,
  input  wire [15:0] dq_in,
  output reg         done_ff,
  output reg  [15:0] rdata_ff,
  output reg  [19:0] fa_ff,
  output reg  [15:0] dq_out_ff,
  output reg         dq_oe_ff,
  output reg         ce_n_ff,
  output reg         we_n_ff,
  output reg         oe_n_ff
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_WR   = 4'b0010;
  localparam [3:0] S_RD   = 4'b0100;
  localparam [3:0] S_GAP  = 4'b1000;
  reg [3:0] st_ff;
  reg [3:0] cnt_ff;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff     <= S_IDLE;
      cnt_ff    <= 4'h0;
      done_ff   <= 1'b0;
      rdata_ff  <= 16'h0000;
      fa_ff     <= 20'h0_0000;
      dq_out_ff <= 16'h0000;
      dq_oe_ff  <= 1'b0;
      ce_n_ff   <= 1'b1;
      we_n_ff   <= 1'b1;
      oe_n_ff   <= 1'b1;
    end else if (ce) begin
      done_ff <= 1'b0;
      case (st_ff)
        S_IDLE: begin
          cnt_ff <= 4'h0;
          fa_ff  <= addr;
          if (go_wr) begin
            dq_out_ff <= wdata;
            dq_oe_ff  <= 1'b1;
            ce_n_ff   <= 1'b0;
            we_n_ff   <= 1'b0;
            st_ff     <= S_WR;
          end else if (go_rd) begin
            ce_n_ff <= 1'b0;
            oe_n_ff <= 1'b0;
            st_ff   <= S_RD;
          end
        end
        S_WR: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff + 4'h1 >= `FCS_WE_CYC) begin
            // Data latched on this rising edge, address and data held one more cycle
            we_n_ff <= 1'b1;
            ce_n_ff <= 1'b1;
            st_ff   <= S_GAP;
          end
        end
        S_RD: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff + 4'h1 >= `FCS_ACC_CYC) begin
            rdata_ff <= dq_in;
            oe_n_ff  <= 1'b1;
            ce_n_ff  <= 1'b1;
            st_ff    <= S_GAP;
          end
        end
        S_GAP: begin
          dq_oe_ff <= 1'b0;
          done_ff  <= 1'b1;
          st_ff    <= S_IDLE;
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end
endmodule

// [verif/fcs_host_assertions.sv]
// Concurrent checks on the pins of the flash host controller
`timescale 1ns/1ps
module fcs_host_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_ff,
  input wire logic [19:0] flash_addr,
  input wire logic        flash_dq_oe,
  input wire logic        flash_ce_n,
  input wire logic        flash_we_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_reset_n_ff,
  input wire logic        ready_busy_out_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // --------------------------------
  // Bus cycle shapes
  // --------------------------------
  sequence s_write_pulse;
    !flash_ce_n && flash_oe_n && flash_dq_oe ##1 flash_we_n && flash_ce_n;
  endsequence
  sequence s_read_hold;
    (!flash_oe_n && !flash_ce_n && flash_we_n)[*2] ##1 flash_oe_n;
  endsequence
  // Read data is frozen, not cleared, while the clock enable is low
  a_rdata_idle: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata_ff == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  a_no_contention: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("host drives data while flash outputs");
  a_write_pulse: assert property ($fell(flash_we_n) |-> s_write_pulse)
    else $error("write pulse malformed");
  a_dq_release: assert property ($rose(flash_we_n) |=> !flash_dq_oe)
    else $error("data not released after write");
  a_read_hold: assert property ($fell(flash_oe_n) |-> s_read_hold)
    else $error("read strobe malformed");
  a_read_addr: assert property (!flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr))
    else $error("address moved during read");
  a_hw_reset_len: assert property ($fell(flash_reset_n_ff) |-> (!flash_reset_n_ff)[*5] ##1 flash_reset_n_ff)
    else $error("hardware reset pulse length wrong");
  a_busy_no_write: assert property (!ready_busy_out_n |-> flash_we_n)
    else $error("write issued while flash busy");
endmodule
bind fcs_host fcs_host_checker i_fcs_host_checker (.clk(clk), .rst_b(rst_b), .ce(ce),
  .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe),
  .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
  .flash_reset_n_ff(flash_reset_n_ff), .ready_busy_out_n(ready_busy_out_n));

// [verif/fcs_flash_model.sv]
// Behavioural parallel flash device facing the host controller
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter logic [15:0] MAKER     = 16'h005A,  // Arbitrary value
  parameter logic [15:0] PART      = 16'h00C3,  // Arbitrary value
  parameter logic [7:0]  PROT_SECT = 8'h07,
  parameter int          BUSY_CYC  = 6
) (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [19:0] addr,
  input  wire logic [15:0] dq_out,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        byte_n,
  input  wire logic        reset_n,
  output logic      [15:0] dq_in,
  output logic             ready_busy_out_n
);
  logic [15:0] mem_ff [16];
  logic [19:0] la_ff;
  logic [15:0] ld_ff, last_ff;
  logic [2:0]  cyc_ff;
  logic        ident_ff, byp_ff, prog_ff, exit_ff, we_q_ff, ce_q_ff;
  int          busy_ff;
  wire  [11:0] u1 = byte_n ? 12'h555 : 12'hAAA;
  wire  [11:0] u2 = byte_n ? 12'h2AA : 12'h555;
  wire  [7:0]  d = ld_ff[7:0];
  wire integer blen = slow ? BUSY_CYC * 20 : BUSY_CYC;
  initial begin
    foreach (mem_ff[i]) mem_ff[i] = 16'hFFFF;
    {cyc_ff, ident_ff, byp_ff, prog_ff, exit_ff, busy_ff, last_ff} = '0;
  end
  assign ready_busy_out_n = (busy_ff == 0);
  always_comb begin
    if (ce_n || oe_n) dq_in = ~last_ff;
    else if (busy_ff > 0) dq_in = {8'h00, ~ld_ff[7], busy_ff[0], 6'h00};
    else if (!ident_ff) dq_in = mem_ff[addr[3:0]];
    else if (addr[7:0] == 8'h00) dq_in = MAKER;
    else if (addr[7:0] == 8'h01) dq_in = PART;
    else if (addr[7:0] == (byte_n ? 8'h02 : 8'h04)) dq_in = {15'h0, addr[19:12] == PROT_SECT};
    else dq_in = 16'h0000;
  end
  always @(posedge clk) begin
    we_q_ff <= we_n;
    ce_q_ff <= ce_n;
    if (!ce_n && !oe_n) last_ff <= dq_in;
    if (!we_n && !ce_n) begin
      la_ff <= addr;
      ld_ff <= dq_out;
    end
    if (!reset_n) {cyc_ff, ident_ff, byp_ff, prog_ff, exit_ff, busy_ff} <= '0;
    else if (busy_ff > 0) busy_ff <= busy_ff - 1;
    else if (!we_q_ff && we_n && !ce_q_ff) begin
      cyc_ff <= 3'd0;
      if (prog_ff) begin
        mem_ff[la_ff[3:0]] <= mem_ff[la_ff[3:0]] & (byte_n ? ld_ff : {8'hFF, ld_ff[7:0]});
        prog_ff <= 1'b0;
        busy_ff <= blen;
      end else if (byp_ff) begin
        exit_ff <= (d == 8'h90);
        if (exit_ff && d == 8'h00) byp_ff <= 1'b0;
        prog_ff <= (d == 8'hA0);
      end else if (d == 8'hF0) ident_ff <= 1'b0;
      else case (cyc_ff)
        3'd0, 3'd3: if (la_ff[11:0] == u1 && d == 8'hAA) cyc_ff <= cyc_ff + 3'd1;
        3'd1, 3'd4: if (la_ff[11:0] == u2 && d == 8'h55) cyc_ff <= cyc_ff + 3'd1;
        3'd2: begin
          ident_ff <= ident_ff || d == 8'h90;
          prog_ff <= (d == 8'hA0);
          byp_ff <= (d == 8'h20);
          if (d == 8'h80) cyc_ff <= 3'd3;
        end
        3'd5: if (d == 8'h10) begin
          foreach (mem_ff[i]) mem_ff[i] <= 16'hFFFF;
          busy_ff <= blen;
        end
        default: cyc_ff <= 3'd0;
      endcase
    end
  end
endmodule

// [verif/fcs_host_tb_top.sv]
// Self-checking testbench for the flash host controller
`timescale 1ns/1ps
`include "fcs_defs.vh"
module fcs_host_tb_top;
  logic        clk, rst_b, ce, reg_wr, reg_rd, slow;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff, rd;
  wire  [19:0] fa;
  wire  [15:0] dqo, dqi;
  wire         dq_oe, ce_n, we_n, oe_n, byte_n, reset_n, rb_n;
  int          miscompares, n_checks;
  fcs_host i_fcs_host (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .flash_addr(fa), .flash_dq_out(dqo), .flash_dq_oe(dq_oe), .flash_dq_in(dqi),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_byte_n_ff(byte_n),
    .flash_reset_n_ff(reset_n), .ready_busy_out_n(rb_n));
  fcs_flash_model i_fcs_flash_model (.clk(clk), .slow(slow), .addr(fa), .dq_out(dqo),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .byte_n(byte_n), .reset_n(reset_n),
    .dq_in(dqi), .ready_busy_out_n(rb_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata_ff;
  endtask
  task automatic issue(input logic [3:0] o, input logic [19:0] a, input logic [15:0] d,
                       input logic bm);
    wr(`FCS_REG_ADDR, {12'h000, a});
    wr(`FCS_REG_WDATA, {16'h0000, d});
    wr(`FCS_REG_CTRL, {27'h0, bm, o});
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 2000; i++) begin
      rdr(`FCS_REG_STATUS, rd);
      if (rd[`FCS_ST_BUSY] === 1'b0) return;
    end
    // A controller that never leaves busy counts as a mismatch
    miscompares++;
  endtask
  task automatic op(input logic [3:0] o, input logic [19:0] a, input logic [15:0] d);
    issue(o, a, d, 1'b0);
    wait_idle();
  endtask
  task automatic rda(input logic [19:0] a, input logic [15:0] exp);
    op(`FCS_OP_READ, a, 16'h0000);
    rdr(`FCS_REG_RDATA, rd);
    check(rd, {16'h0000, exp});
  endtask
  task automatic st(input int b, input logic e);
    rdr(`FCS_REG_STATUS, rd);
    check({31'h0, rd[b]}, {31'h0, e});
  endtask
  // --------------------------------
  // Clock and watchdog
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    {rst_b, reg_wr, reg_rd, slow, reg_addr, reg_wdata, miscompares, n_checks} = '0;
    ce = 1'b1;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    check({26'h0, ce_n, we_n, oe_n, dq_oe, byte_n, reset_n}, 32'h0000_003B);
    rda(20'h0_0003, 16'hFFFF);
    op(`FCS_OP_PROG, 20'h0_0003, 16'h1234);
    st(`FCS_ST_DONE, 1'b1);
    st(`FCS_ST_TIMEOUT, 1'b0);
    rda(20'h0_0003, 16'h1234);
    slow <= 1'b1;
    op(`FCS_OP_PROG, 20'h0_0003, 16'hFFFF);
    rda(20'h0_0003, 16'h1234);
    slow <= 1'b0;
    op(`FCS_OP_IDENT, 20'h0_0000, 16'h0000);
    st(`FCS_ST_IDENT, 1'b1);
    rda(20'h0_0000, 16'h005A);
    rda(20'h0_0001, 16'h00C3);
    rda(20'h0_0000, 16'h005A);
    rda(20'h0_7002, 16'h0001);
    rda(20'h0_1002, 16'h0000);
    op(`FCS_OP_RESET, 20'h0_0000, 16'h0000);
    st(`FCS_ST_IDENT, 1'b0);
    rda(20'h0_0003, 16'h1234);
    op(`FCS_OP_BYP_ENTER, 20'h0_0000, 16'h0000);
    st(`FCS_ST_BYPASS, 1'b1);
    op(`FCS_OP_BYP_PROG, 20'h0_0005, 16'h0055);
    op(`FCS_OP_BYP_PROG, 20'hF_F009, 16'hA5A5);
    op(`FCS_OP_PROG, 20'h0_0007, 16'h0000);
    st(`FCS_ST_REJECT, 1'b1);
    op(`FCS_OP_BYP_EXIT, 20'h0_0000, 16'h0000);
    st(`FCS_ST_BYPASS, 1'b0);
    rda(20'h0_0005, 16'h0055);
    rda(20'hF_F009, 16'hA5A5);
    issue(`FCS_OP_PROG, 20'h0_0006, 16'h12AB, 1'b1);
    wait_idle();
    rda(20'h0_0006, 16'hFFAB);
    // Busy is long here; the extra order lands while the erase command sequence is still being issued
    slow <= 1'b1;
    issue(`FCS_OP_CHIP_ERASE, 20'h0_0000, 16'h0000, 1'b0);
    wr(`FCS_REG_CTRL, {28'h0, `FCS_OP_PROG});
    wait_idle();
    st(`FCS_ST_REJECT, 1'b0);
    rda(20'h0_0003, 16'hFFFF);
    rda(20'h0_0005, 16'hFFFF);
    slow <= 1'b0;
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    op(`FCS_OP_IDENT, 20'h0_0000, 16'h0000);
    op(`FCS_OP_HW_RESET, 20'h0_0000, 16'h0000);
    st(`FCS_ST_IDENT, 1'b0);
    rda(20'h0_0000, 16'hFFFF);
    op(4'h0, 20'h0_0000, 16'h0000);
    st(`FCS_ST_REJECT, 1'b1);
    rdr(4'hF, rd);
    check(rd, 32'h0000_0000);
    print_verdict();
  end
endmodule
